// >>> rtl/rpmc_ctrl.v
// Reset sequencing and power-mode control for the 8-bit core
// Assumes an SFR bus on clk_sys_i; pin and comparator inputs are async
`timescale 1ns/1ns
`default_nettype none
`include "rpmc_consts.vh"
module rpmc_ctrl #(
  parameter POR_DELAY_CYC = `RPMC_POR_DELAY_CYC
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire rst_pin_n_i,
  input wire supply_ok_i,
  input wire other_reset_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire irq_wake_i,
  output reg [7:0] sfr_rdata_o,
  output reg core_reset_o,
  output reg rst_pin_n_o,
  output reg rst_pin_oe_o,
  output reg cpu_clk_en_o,
  output reg osc_run_o,
  output reg periph_clk_en_o,
  output reg [7:0] port_latch_o,
  output reg port_open_drain_o,
  output reg port_pullup_en_o,
  output reg [15:0] pc_load_o,
  output reg sp_reinit_o,
  output reg int_timer_dis_o,
  output reg wdt_en_o,
  output reg [3:0] wdt_div_o,
  output reg sysclk_internal_o,
  output reg mon_en_o,
  output reg mon_sel_o
);
  localparam ST_POR = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_MONRST = 2'd3;
  localparam CW = 24;

  wire [1:0] sync_w;
  wire pin_n_s;
  wire supply_s;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [5:0] flags_r;
  reg idle_r;
  reg stop_r;
  reg por_flag_r;
  reg mon_en_r;
  reg mon_sel_r;
  reg in_reset_w;
  reg pin_driven_w;
  reg [2:0] oe_hist_r;

  // Address match used by both write and read paths
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // Pin and comparator are off-domain; synchronise before use
  rpmc_sync2 #(.W(2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .async_i({rst_pin_n_i, supply_ok_i}),
    .sync_o(sync_w)
  );
  assign pin_n_s = sync_w[1];
  assign supply_s = sync_w[0];

  // Monitor reset only counts while it is enabled and software has selected it
  wire mon_trip_w = mon_en_r && mon_sel_r && !supply_s;
  // Our own pull-down echoes back through the synchroniser; ignore it
  wire pin_reset_w = !pin_n_s && !rst_pin_oe_o && !(|oe_hist_r);
  wire soft_reset_w = pin_reset_w || other_reset_i;

  // Recent drive history of the pin covers the two-stage sync lag
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      oe_hist_r <= 3'h7;
    end else begin
      oe_hist_r <= {oe_hist_r[1:0], rst_pin_oe_o};
    end
  end

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_POR: begin
        if (supply_s) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!supply_s) begin
          state_nxt = ST_POR;
        end else if (cnt_r == POR_DELAY_CYC[CW-1:0] - 24'h000001) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mon_trip_w) begin
          state_nxt = ST_MONRST;
        end
      end
      default: begin
        if (supply_s) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  always @* begin
    in_reset_w = (state_r != ST_RUN) || soft_reset_w;
    pin_driven_w = (state_r != ST_RUN);
  end

  // State and delay counter
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_POR;
      cnt_r <= {CW{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_DELAY && state_nxt == ST_DELAY) begin
        cnt_r <= cnt_r + 24'h000001;
      end else begin
        cnt_r <= {CW{1'b0}};
      end
    end
  end

  // Power control and reset-cause state
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      flags_r <= 6'h00;
      idle_r <= 1'b0;
      stop_r <= 1'b0;
      por_flag_r <= 1'b0;
      mon_en_r <= 1'b1;
      mon_sel_r <= 1'b0;
    end else if (in_reset_w) begin
      // Registers back to defaults, mon_en_r only at power-on, por_flag_r to cause; memory is not touched here
      flags_r <= 6'h00;
      idle_r <= 1'b0;
      stop_r <= 1'b0;
      mon_sel_r <= 1'b0;
      if (state_r == ST_POR || state_r == ST_DELAY) begin
        mon_en_r <= 1'b1;
      end
      if (state_r != ST_RUN) begin
        por_flag_r <= 1'b1;
      end else begin
        por_flag_r <= 1'b0;
      end
    end else begin
      if (sfr_wr_i && is_addr(sfr_addr_i, `RPMC_ADDR_PWR_CTL)) begin
        flags_r <= sfr_wdata_i[7:2];
        if (sfr_wdata_i[`RPMC_BIT_STOP]) begin
          stop_r <= 1'b1;
        end
        if (sfr_wdata_i[`RPMC_BIT_IDLE]) begin
          idle_r <= 1'b1;
        end
      end else if (irq_wake_i) begin
        idle_r <= 1'b0;
      end
      // Stop has no exit here besides reset
      if (sfr_wr_i && is_addr(sfr_addr_i, `RPMC_ADDR_RST_CAUSE)) begin
        mon_sel_r <= sfr_wdata_i[`RPMC_BIT_POR_FLAG];
      end
      if (sfr_wr_i && is_addr(sfr_addr_i, `RPMC_ADDR_MON_CTL)) begin
        mon_en_r <= sfr_wdata_i[`RPMC_BIT_MON_EN];
      end
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (is_addr(sfr_addr_i, `RPMC_ADDR_PWR_CTL)) begin
        sfr_rdata_o <= {flags_r, 2'b00};
      end else if (is_addr(sfr_addr_i, `RPMC_ADDR_RST_CAUSE)) begin
        sfr_rdata_o <= {6'h00, por_flag_r, 1'b0};
      end else if (is_addr(sfr_addr_i, `RPMC_ADDR_MON_CTL)) begin
        sfr_rdata_o <= {mon_en_r, supply_s, 6'h00};
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // Reset-state effects and exit defaults, all registered
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      rst_pin_n_o <= 1'b0;
      rst_pin_oe_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      osc_run_o <= 1'b1;
      periph_clk_en_o <= 1'b0;
      port_latch_o <= `RPMC_PORT_RESET;
      port_open_drain_o <= 1'b1;
      port_pullup_en_o <= 1'b1;
      pc_load_o <= `RPMC_PC_RESET;
      sp_reinit_o <= 1'b1;
      int_timer_dis_o <= 1'b1;
      wdt_en_o <= 1'b0;
      wdt_div_o <= 4'h0;
      sysclk_internal_o <= 1'b1;
      mon_en_o <= 1'b1;
      mon_sel_o <= 1'b0;
    end else begin
      core_reset_o <= in_reset_w;
      rst_pin_n_o <= 1'b0;
      rst_pin_oe_o <= pin_driven_w;
      cpu_clk_en_o <= !in_reset_w && !idle_r && !stop_r;
      osc_run_o <= !stop_r;
      periph_clk_en_o <= !in_reset_w && !stop_r;
      port_latch_o <= `RPMC_PORT_RESET;
      port_open_drain_o <= 1'b1;
      port_pullup_en_o <= 1'b1;
      pc_load_o <= `RPMC_PC_RESET;
      sp_reinit_o <= in_reset_w;
      int_timer_dis_o <= in_reset_w || stop_r;
      wdt_en_o <= !in_reset_w;
      wdt_div_o <= 4'hC;
      sysclk_internal_o <= 1'b1;
      mon_en_o <= mon_en_r;
      mon_sel_o <= mon_sel_r;
    end
  end
endmodule // rpmc_ctrl
`default_nettype wire

// >>> rtl/rpmc_consts.vh
// Constants for the reset and power-mode control block
// Assumes an 8-bit special-function-register bus on the system clock
// Contract
// - Six software flags, bits 7:2, no effect
// - Stop bit write enters stop, oscillator halted
// - Idle bit write gates CPU clock only
// - Stop and idle bits always read zero
// - Reset halts CPU, resets registers, ports, timers
// - Data memory untouched; stack pointer reinitialised
// - Port latches all ones, pull-ups enabled
// - Power-on/monitor reset drives reset pin low
// - Exit: PC zero, internal oscillator, fetch zero
// - Exit: watchdog enabled, clocked sysclk/12
// - Power-up holds reset, then release delay
// - Power-on/monitor exit sets power-on flag
// - Other reset causes clear power-on flag
// - Power-on enables monitor; others keep it
// - Supply low holds reset until recovered
// - Monitor reset skips power-up release delay
// - Writing flag position selects monitor reset
// - Interrupt or reset ends idle
// - Only reset ends stop mode
`ifndef RPMC_CONSTS_VH
`define RPMC_CONSTS_VH
`define RPMC_ADDR_PWR_CTL 8'h87
`define RPMC_ADDR_RST_CAUSE 8'hEF
`define RPMC_ADDR_MON_CTL 8'hFF
`define RPMC_PWR_CTL_RESET 8'h00
`define RPMC_BIT_IDLE 0
`define RPMC_BIT_STOP 1
`define RPMC_BIT_POR_FLAG 1
`define RPMC_BIT_MON_EN 7
`define RPMC_BIT_MON_STAT 6
`define RPMC_PORT_RESET 8'hFF
`define RPMC_PC_RESET 16'h0000
`define RPMC_WDT_DIV 12
`define RPMC_CLK_MHZ 125
`define RPMC_POR_DELAY_US 300
`define RPMC_POR_DELAY_CYC (`RPMC_POR_DELAY_US * `RPMC_CLK_MHZ)
`endif

// >>> rtl/rpmc_sync2.v
// Two-flip-flop synchroniser for asynchronous level inputs
// Assumes inputs are slow levels; only the second stage is read
`timescale 1ns/1ns
`default_nettype none
module rpmc_sync2 #(
  parameter W = 2
) (
  input wire clk_sys_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // No reset so the chain tracks the pin even while reset is held
  always @(posedge clk_sys_i) begin
    meta_r <= async_i;
    sync_r <= meta_r;
  end

  assign sync_o = sync_r;
endmodule // rpmc_sync2
`default_nettype wire

// >>> tb/rpmc_far_model.sv
// Far side: supply comparator and external reset pin
// Dip input comes from the bench at the falling edge
`timescale 1ns/1ns
`default_nettype none
module rpmc_far_model (
  input wire logic dip_i,
  output wire logic supply_ok_o,
  output wire logic pin_n_o
);
  // Comparator lags, so it never moves on a clock edge
  assign #3 supply_ok_o = !dip_i;
  // Nobody pulls the pin; the pull-up holds it high
  assign pin_n_o = 1'b1;
endmodule // rpmc_far_model
`default_nettype wire

// >>> tb/rpmc_ctrl_props.sv
// Assertion checker for rpmc_ctrl
// Bound to every instance; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module rpmc_ctrl_props #(
  parameter POR_DELAY_CYC = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic other_reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic irq_wake_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic core_reset_o,
  input wire logic rst_pin_n_o,
  input wire logic rst_pin_oe_o,
  input wire logic cpu_clk_en_o,
  input wire logic osc_run_o,
  input wire logic int_timer_dis_o,
  input wire logic wdt_en_o,
  input wire logic mon_en_o,
  input wire logic mon_sel_o
);
  // Accepted power-control write
  wire wr_pc = sfr_wr_i && sfr_addr_i == 8'h87 && !core_reset_o && !other_reset_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_mode_reads_zero: assert property (
    sfr_rd_i && sfr_addr_i == 8'h87 && !core_reset_o |=> sfr_rdata_o[1:0] == 2'b00)
    else $error("mode bits read back nonzero");
  chk_stop_entry: assert property (
    wr_pc && sfr_wdata_i[1] |-> ##2 !osc_run_o && !cpu_clk_en_o)
    else $error("stop write did not halt");
  chk_stop_held: assert property (
    (!osc_run_o && !core_reset_o && !other_reset_i)[*3] |=> !osc_run_o || core_reset_o)
    else $error("stop left without reset");
  chk_idle_gate: assert property (
    wr_pc && sfr_wdata_i[1:0] == 2'b01 && !irq_wake_i ##1 !irq_wake_i
    |=> !cpu_clk_en_o && osc_run_o)
    else $error("idle write did not gate cpu only");
  chk_idle_wake: assert property (
    !cpu_clk_en_o && osc_run_o && !core_reset_o && irq_wake_i && !sfr_wr_i
    |-> ##[1:2] cpu_clk_en_o)
    else $error("interrupt did not end idle");
  chk_monitor_pin: assert property (
    (!supply_ok_i && mon_en_o && mon_sel_o)[*4]
    |=> core_reset_o && rst_pin_oe_o && !rst_pin_n_o)
    else $error("low supply did not hold reset");
  chk_monitor_kept: assert property (
    !mon_en_o && !(sfr_wr_i && sfr_addr_i == 8'hFF)
    && !$past(sfr_wr_i && sfr_addr_i == 8'hFF) |=> !mon_en_o)
    else $error("monitor enable changed");
  chk_reset_state: assert property (
    core_reset_o |-> int_timer_dis_o && !cpu_clk_en_o)
    else $error("reset state incomplete");
  chk_por_hold: assert property (
    $fell(rst_i) |-> core_reset_o[*8])
    else $error("power-up released too early");
  chk_wdt_on_exit: assert property (
    $fell(core_reset_o) |-> wdt_en_o)
    else $error("watchdog off after reset");
endmodule // rpmc_ctrl_props
bind rpmc_ctrl rpmc_ctrl_props #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_props (
  .clk_sys_i, .rst_i, .supply_ok_i, .other_reset_i, .sfr_addr_i, .sfr_wdata_i,
  .sfr_wr_i, .sfr_rd_i, .irq_wake_i, .sfr_rdata_o, .core_reset_o, .rst_pin_n_o,
  .rst_pin_oe_o, .cpu_clk_en_o, .osc_run_o, .int_timer_dis_o, .wdt_en_o,
  .mon_en_o, .mon_sel_o);
`default_nettype wire

// >>> tb/reset_and_power_mode_control_tb_top.sv
// Self-checking bench for rpmc_ctrl
// Far-side model gives the supply level and the external pin
`timescale 1ns/1ns
`default_nettype none
module reset_and_power_mode_control_tb_top;
  logic clk_sys_i, rst_i, other_reset_i, sfr_wr_i, sfr_rd_i, irq_wake_i, dip;
  logic [7:0] sfr_addr_i, sfr_wdata_i, d;
  wire [7:0] sfr_rdata_o, port_latch_o;
  wire [15:0] pc_load_o;
  wire [3:0] wdt_div_o;
  wire core_reset_o, rst_pin_n_o, rst_pin_oe_o, cpu_clk_en_o, osc_run_o, periph_clk_en_o;
  wire port_open_drain_o, port_pullup_en_o, sp_reinit_o, int_timer_dis_o, wdt_en_o;
  wire sysclk_internal_o, mon_en_o, mon_sel_o, supply_ok, ext_pin_n;
  integer fails = 0, checks = 0, seed = 32'h5542, i, n;
  // Wired-AND pin: device pull-down and outside world
  wire pin_w = (rst_pin_oe_o ? rst_pin_n_o : 1'b1) & ext_pin_n;
  rpmc_far_model i_far (.dip_i(dip), .supply_ok_o(supply_ok), .pin_n_o(ext_pin_n));
  rpmc_ctrl #(.POR_DELAY_CYC(8)) i_dut (.clk_sys_i, .rst_i, .rst_pin_n_i(pin_w),
    .supply_ok_i(supply_ok), .other_reset_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
    .sfr_rd_i, .irq_wake_i, .sfr_rdata_o, .core_reset_o, .rst_pin_n_o, .rst_pin_oe_o,
    .cpu_clk_en_o, .osc_run_o, .periph_clk_en_o, .port_latch_o, .port_open_drain_o,
    .port_pullup_en_o, .pc_load_o, .sp_reinit_o, .int_timer_dis_o, .wdt_en_o,
    .wdt_div_o, .sysclk_internal_o, .mon_en_o, .mon_sel_o);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus strobes rise and fall on falling edges only
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    chk("rdata", {8'h00, e}, {8'h00, sfr_rdata_o & m});
  endtask
  task automatic cyc(input integer k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  // Bounded wait for release; n holds the cycles taken
  task automatic wait_run(input integer lim);
    n = 0;
    while (core_reset_o !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    chk("release", 16'h1, {15'h0, n < lim});
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, far beyond the roughly 150 cycles needed
  initial begin
    #40000;
    fails++;
    tally_and_finish;
  end
  initial begin
    {rst_i, dip, other_reset_i, sfr_wr_i, sfr_rd_i, irq_wake_i} = 6'b110000;
    {sfr_addr_i, sfr_wdata_i} = 16'h0000;
    cyc(4);
    rst_i = 1'b0;
    cyc(5);
    chk("pup", 16'h3, {core_reset_o, rst_pin_oe_o} & {1'b1, ~rst_pin_n_o});
    dip = 1'b0;
    wait_run(40);
    chk("delay", 16'h1, {15'h0, n >= 8});
    chk("statics", 16'hFFFC, {port_latch_o, port_open_drain_o, port_pullup_en_o,
      wdt_en_o, sysclk_internal_o, wdt_div_o});
    chk("pc", 16'h0000, pc_load_o);
    rd(8'h87, 8'h00, 8'hFF);
    rd(8'hEF, 8'h02, 8'h02);
    chk("mon on", 16'h1, {15'h0, mon_en_o});
    for (i = 0; i < 6; i++) begin
      d = $random(seed) & 8'hFC;
      wr(8'h87, d);
      rd(8'h87, d, 8'hFF);
      wr(8'h87, d | 8'h01);
      cyc(1);
      chk("idle", 16'h3, {cpu_clk_en_o, periph_clk_en_o, osc_run_o});
      irq_wake_i = 1'b1;
      cyc(1);
      irq_wake_i = 1'b0;
      cyc(2);
      rd(8'h87, d, 8'hFF);
    end
    rd(8'h10, 8'h00, 8'hFF);
    wr(8'hFF, 8'h00);
    other_reset_i = 1'b1;
    cyc(3);
    chk("sw rst", 16'h7, {core_reset_o, sp_reinit_o, int_timer_dis_o});
    chk("no pin", 16'h0, {15'h0, rst_pin_oe_o});
    other_reset_i = 1'b0;
    wait_run(20);
    chk("mon kept", 16'h0, {15'h0, mon_en_o});
    rd(8'hEF, 8'h00, 8'h02);
    wr(8'hFF, 8'h80);
    cyc(4);
    wr(8'hEF, 8'h02);
    cyc(1);
    chk("mon sel", 16'h1, {15'h0, mon_sel_o});
    dip = 1'b1;
    cyc(5);
    chk("dip", 16'h6, {core_reset_o, rst_pin_oe_o, rst_pin_n_o});
    dip = 1'b0;
    wait_run(40);
    chk("fast", 16'h1, {15'h0, n < 8});
    rd(8'hEF, 8'h02, 8'h02);
    wr(8'h87, 8'hFE);
    cyc(1);
    chk("stop", 16'h1, {osc_run_o, cpu_clk_en_o, int_timer_dis_o});
    irq_wake_i = 1'b1;
    cyc(10);
    irq_wake_i = 1'b0;
    chk("stuck", 16'h0, {15'h0, osc_run_o});
    other_reset_i = 1'b1;
    cyc(2);
    other_reset_i = 1'b0;
    wait_run(20);
    cyc(1);
    chk("resume", 16'h3, {osc_run_o, cpu_clk_en_o});
    rd(8'h87, 8'h00, 8'hFF);
    tally_and_finish;
  end
endmodule // reset_and_power_mode_control_tb_top
`default_nettype wire
